// >>> shared/xbfa_pkg.sv
// Constants, field layout and state encoding of the expansion bus master.
// Assumes a single 50 MHz core clock; all counts are in core clock cycles.

package xbfa_pkg;

    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int DATA_W     = 32;
    localparam int ADDR_W     = 4;
    localparam int SPACE_W    = 2;
    localparam int NUM_SPACES = 4;
    localparam int CNT_W      = 4;
    localparam int FIFO_DEPTH = 8;

    // ------------------------------------------------------------------
    // Request word layout
    // ------------------------------------------------------------------
    localparam int REQ_DATA_LSB  = 0;
    localparam int REQ_ADDR_LSB  = 32;
    localparam int REQ_SPACE_LSB = 36;
    localparam int REQ_GLUE_BIT  = 38;
    localparam int REQ_FIFO_BIT  = 39;
    localparam int REQ_WRITE_BIT = 40;
    localparam int REQ_W         = 41;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 20;
    localparam int WAKE_MAX_NS   = 80;
    localparam int WAKE_CYCLES   = WAKE_MAX_NS / CLK_PERIOD_NS;
    localparam logic [2:0] WAKE_DRIVE = 3'(WAKE_CYCLES - 1);
    localparam logic [2:0] BOOT_TAKE  = 3'h2;
    localparam logic [3:0] READY_EVAL_LEAD = 4'h3;
    localparam logic [4:0] EXT_MIN_SUM     = 5'h04;
    localparam logic [1:0] GLUELESS_SPACE  = 2'h3;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [3:0]  RST_SEL_B = 4'hF;
    localparam logic [3:0]  RST_ADDR  = 4'h0;
    localparam logic [31:0] RST_DATA  = 32'h0000_0000;

    typedef enum logic [4:0] {
        ST_IDLE    = 5'h01,
        ST_ASETUP  = 5'h02,
        ST_ASTROBE = 5'h04,
        ST_AHOLD   = 5'h08,
        ST_FACC    = 5'h10
    } xbfa_state_t;

endpackage : xbfa_pkg

// >>> verilog/xbfa_port.sv
// Expansion bus master for synchronous FIFO and asynchronous peripheral
// accesses, with its request FIFO.
// Assumes requests come from logic on clock; bus pins are asynchronous.

`timescale 1ns/1ns

module xbfa_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             rst_b,
    input  wire logic             ce,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wr_ptr;
    logic [PW-1:0]    rd_ptr;
    logic [PW:0]      count;
    logic             push;
    logic             pop;
    logic [PW:0]      next_count;

    assign push       = in_valid & in_ready;
    assign pop        = out_valid & out_ready;
    assign next_count = count + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
    assign out_data   = mem[rd_ptr];

    always_ff @(posedge clock) begin
        if (ce && push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            wr_ptr    <= '0;
            rd_ptr    <= '0;
            count     <= '0;
            in_ready  <= 1'b0;
            out_valid <= 1'b0;
        end else if (ce) begin
            if (push) begin
                wr_ptr <= PW'((wr_ptr + 1'b1) % DEPTH);
            end
            if (pop) begin
                rd_ptr <= PW'((rd_ptr + 1'b1) % DEPTH);
            end
            count     <= next_count;
            // Registered flags keep the full/empty view honest
            in_ready  <= next_count != (PW + 1)'(DEPTH);
            out_valid <= next_count != '0;
        end
    end

endmodule : xbfa_fifo

module xbfa_port (
    // Clock, reset, enable
    input  wire logic        clock,
    input  wire logic        rst_b,
    input  wire logic        ce,
    // Request port
    input  wire logic        req_valid,
    output logic             req_ready,
    input  wire logic        req_write,
    input  wire logic        req_fifo_mode,
    input  wire logic        req_glueless,
    input  wire logic [1:0]  req_space,
    input  wire logic [3:0]  req_addr,
    input  wire logic [31:0] req_wdata,
    // Read answer and status
    output logic             rd_valid,
    output logic [31:0]      rd_data,
    output logic             busy,
    output logic             boot_valid,
    output logic [31:0]      boot_config,
    // Per-space timing, four bits per space, space 0 lowest
    input  wire logic [15:0] read_setup_count,
    input  wire logic [15:0] read_strobe_count,
    input  wire logic [15:0] read_hold_count,
    input  wire logic [15:0] write_setup_count,
    input  wire logic [15:0] write_strobe_count,
    input  wire logic [15:0] write_hold_count,
    // Bus control and address pins, bit 3 of selects is space three
    output logic [3:0]       chip_space_select_b,
    output logic [3:0]       byte_enable_or_low_address,
    output logic             read_strobe_b,
    output logic             output_enable_strobe_b,
    output logic             write_strobe_or_wait_b,
    output logic             fifo_bus_clock,
    output logic             ctrl_oe,
    // Data pins
    input  wire logic [31:0] expansion_data_lines_in,
    output logic [31:0]      expansion_data_lines_out,
    output logic             expansion_data_lines_oe,
    // Ready pin
    input  wire logic        peripheral_ready_input
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [3:0] fn_pick(input logic [15:0] v,
                                           input logic [1:0]  sp);
        fn_pick = v[{sp, 2'b00} +: 4];
    endfunction : fn_pick

    // Zero is taken as one cycle so every phase is seen on the pins
    function automatic logic [3:0] fn_eff(input logic [3:0] x);
        fn_eff = (x == 4'h0) ? 4'h1 : x;
    endfunction : fn_eff

    // ------------------------------------------------------------------
    // Request FIFO
    // ------------------------------------------------------------------
    logic [xbfa_pkg::REQ_W-1:0] fifo_in;
    logic [xbfa_pkg::REQ_W-1:0] fifo_out;
    logic                       fifo_valid;
    logic                       take;

    assign fifo_in = {req_write, req_fifo_mode, req_glueless, req_space,
                      req_addr, req_wdata};

    xbfa_fifo #(
        .WIDTH (xbfa_pkg::REQ_W),
        .DEPTH (xbfa_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clock     (clock),
        .rst_b     (rst_b),
        .ce        (ce),
        .in_valid  (req_valid),
        .in_ready  (req_ready),
        .in_data   (fifo_in),
        .out_valid (fifo_valid),
        .out_ready (take),
        .out_data  (fifo_out)
    );

    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    logic        rdy_s1;
    logic        rdy_s2;
    logic [31:0] dat_s1;
    logic [31:0] dat_s2;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rdy_s1 <= 1'b0;
            rdy_s2 <= 1'b0;
            dat_s1 <= xbfa_pkg::RST_DATA;
            dat_s2 <= xbfa_pkg::RST_DATA;
        end else if (ce) begin
            rdy_s1 <= peripheral_ready_input;
            rdy_s2 <= rdy_s1;
            dat_s1 <= expansion_data_lines_in;
            dat_s2 <= dat_s1;
        end
    end

    // ------------------------------------------------------------------
    // Wake-up after reset and boot configuration
    // ------------------------------------------------------------------
    logic [2:0] wake;
    logic       awake;

    assign awake = wake == xbfa_pkg::WAKE_DRIVE;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            wake <= 3'h0;
        end else if (ce && !awake) begin
            wake <= wake + 3'h1;
        end
    end

    // Pins tristate at once under reset, driven once wake completes
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_oe <= 1'b0;
        end else if (ce && awake) begin
            ctrl_oe <= 1'b1;
        end
    end

    // Sampled once the synchroniser has filled with the strap levels
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            boot_valid  <= 1'b0;
            boot_config <= xbfa_pkg::RST_DATA;
        end else if (ce && !boot_valid && wake == xbfa_pkg::BOOT_TAKE) begin
            boot_valid  <= 1'b1;
            boot_config <= dat_s2;
        end
    end

    // ------------------------------------------------------------------
    // FIFO bus clock, core clock divided by two
    // ------------------------------------------------------------------
    logic rise_next;

    assign rise_next = awake && !fifo_bus_clock;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            fifo_bus_clock <= 1'b0;
        end else if (ce && awake) begin
            fifo_bus_clock <= !fifo_bus_clock;
        end
    end

    // ------------------------------------------------------------------
    // Access sequencer
    // ------------------------------------------------------------------
    xbfa_pkg::xbfa_state_t state;
    logic        cur_write;
    logic        cur_glue;
    logic [1:0]  cur_space;
    logic [3:0]  cur_addr;
    logic [31:0] cur_data;
    logic [3:0]  t_setup;
    logic [3:0]  t_strobe;
    logic [3:0]  t_hold;
    logic [3:0]  cnt;
    logic [1:0]  fstep;
    logic [3:0]  eval_at;
    logic        may_extend;
    logic [3:0]  sel_code;

    assign take = ce && awake && boot_valid && fifo_valid
                  && state == xbfa_pkg::ST_IDLE;
    assign may_extend = ({1'b0, t_setup} + {1'b0, t_strobe})
                        >= xbfa_pkg::EXT_MIN_SUM;
    assign eval_at = (t_strobe >= xbfa_pkg::READY_EVAL_LEAD)
                     ? t_strobe - xbfa_pkg::READY_EVAL_LEAD
                     : 4'h0;
    assign sel_code = ~(4'h1 << cur_space);

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state     <= xbfa_pkg::ST_IDLE;
            cur_write <= 1'b0;
            cur_glue  <= 1'b0;
            cur_space <= 2'h0;
            cur_addr  <= xbfa_pkg::RST_ADDR;
            cur_data  <= xbfa_pkg::RST_DATA;
            t_setup   <= 4'h1;
            t_strobe  <= 4'h1;
            t_hold    <= 4'h1;
            cnt       <= 4'h0;
            fstep     <= 2'h0;
        end else if (ce) begin
            case (state)
                xbfa_pkg::ST_IDLE: begin
                    if (take) begin
                        cur_write <= fifo_out[xbfa_pkg::REQ_WRITE_BIT];
                        cur_space <= fifo_out[xbfa_pkg::REQ_SPACE_LSB +: 2];
                        cur_addr  <= fifo_out[xbfa_pkg::REQ_ADDR_LSB +: 4];
                        cur_data  <= fifo_out[xbfa_pkg::REQ_DATA_LSB +: 32];
                        // Glueless fallback to standard outside space three
                        cur_glue  <= fifo_out[xbfa_pkg::REQ_GLUE_BIT]
                                     && fifo_out[xbfa_pkg::REQ_SPACE_LSB +: 2]
                                        == xbfa_pkg::GLUELESS_SPACE;
                        cnt       <= 4'h0;
                        fstep     <= 2'h0;
                        if (fifo_out[xbfa_pkg::REQ_WRITE_BIT]) begin
                            t_setup  <= fn_eff(fn_pick(write_setup_count,
                                fifo_out[xbfa_pkg::REQ_SPACE_LSB +: 2]));
                            t_strobe <= fn_eff(fn_pick(write_strobe_count,
                                fifo_out[xbfa_pkg::REQ_SPACE_LSB +: 2]));
                            t_hold   <= fn_eff(fn_pick(write_hold_count,
                                fifo_out[xbfa_pkg::REQ_SPACE_LSB +: 2]));
                        end else begin
                            t_setup  <= fn_eff(fn_pick(read_setup_count,
                                fifo_out[xbfa_pkg::REQ_SPACE_LSB +: 2]));
                            t_strobe <= fn_eff(fn_pick(read_strobe_count,
                                fifo_out[xbfa_pkg::REQ_SPACE_LSB +: 2]));
                            t_hold   <= fn_eff(fn_pick(read_hold_count,
                                fifo_out[xbfa_pkg::REQ_SPACE_LSB +: 2]));
                        end
                        state <= fifo_out[xbfa_pkg::REQ_FIFO_BIT]
                                 ? xbfa_pkg::ST_FACC : xbfa_pkg::ST_ASETUP;
                    end
                end
                xbfa_pkg::ST_ASETUP: begin
                    if (cnt == t_setup - 4'h1) begin
                        cnt   <= 4'h0;
                        state <= xbfa_pkg::ST_ASTROBE;
                    end else begin
                        cnt <= cnt + 4'h1;
                    end
                end
                xbfa_pkg::ST_ASTROBE: begin
                    if (may_extend && cnt == eval_at && !rdy_s2) begin
                        cnt <= cnt;
                    end else if (cnt == t_strobe - 4'h1) begin
                        cnt   <= 4'h0;
                        state <= xbfa_pkg::ST_AHOLD;
                    end else begin
                        cnt <= cnt + 4'h1;
                    end
                end
                xbfa_pkg::ST_AHOLD: begin
                    if (cnt == t_hold - 4'h1) begin
                        cnt   <= 4'h0;
                        state <= xbfa_pkg::ST_IDLE;
                    end else begin
                        cnt <= cnt + 4'h1;
                    end
                end
                xbfa_pkg::ST_FACC: begin
                    if (rise_next) begin
                        fstep <= fstep + 2'h1;
                        if (fstep == 2'h2
                            || (fstep == 2'h1 && (cur_write || cur_glue))) begin
                            state <= xbfa_pkg::ST_IDLE;
                        end
                    end
                end
                default: begin
                    state <= xbfa_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Pin drivers, registered
    // ------------------------------------------------------------------
    logic a_done;

    // Last strobe cycle of an asynchronous access
    assign a_done = state == xbfa_pkg::ST_ASTROBE
                    && !(may_extend && cnt == eval_at && !rdy_s2)
                    && cnt == t_strobe - 4'h1;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            chip_space_select_b        <= xbfa_pkg::RST_SEL_B;
            byte_enable_or_low_address <= xbfa_pkg::RST_ADDR;
            read_strobe_b              <= 1'b1;
            output_enable_strobe_b     <= 1'b1;
            write_strobe_or_wait_b     <= 1'b1;
            expansion_data_lines_out   <= xbfa_pkg::RST_DATA;
            expansion_data_lines_oe    <= 1'b0;
        end else if (ce) begin
            case (state)
                xbfa_pkg::ST_IDLE: begin
                    if (take && !fifo_out[xbfa_pkg::REQ_FIFO_BIT]) begin
                        chip_space_select_b <= ~(4'h1 <<
                            fifo_out[xbfa_pkg::REQ_SPACE_LSB +: 2]);
                        byte_enable_or_low_address <=
                            fifo_out[xbfa_pkg::REQ_ADDR_LSB +: 4];
                        output_enable_strobe_b <=
                            fifo_out[xbfa_pkg::REQ_WRITE_BIT];
                        expansion_data_lines_out <=
                            fifo_out[xbfa_pkg::REQ_DATA_LSB +: 32];
                        expansion_data_lines_oe <=
                            fifo_out[xbfa_pkg::REQ_WRITE_BIT];
                    end
                end
                xbfa_pkg::ST_ASETUP: begin
                    if (cnt == t_setup - 4'h1) begin
                        read_strobe_b          <= cur_write;
                        write_strobe_or_wait_b <= !cur_write;
                    end
                end
                xbfa_pkg::ST_ASTROBE: begin
                    if (a_done) begin
                        read_strobe_b          <= 1'b1;
                        write_strobe_or_wait_b <= 1'b1;
                    end
                end
                xbfa_pkg::ST_AHOLD: begin
                    if (cnt == t_hold - 4'h1) begin
                        chip_space_select_b     <= xbfa_pkg::RST_SEL_B;
                        output_enable_strobe_b  <= 1'b1;
                        expansion_data_lines_oe <= 1'b0;
                    end
                end
                xbfa_pkg::ST_FACC: begin
                    if (rise_next) begin
                        if (fstep == 2'h0) begin
                            chip_space_select_b        <= sel_code;
                            byte_enable_or_low_address <= cur_addr;
                            write_strobe_or_wait_b     <= !cur_write;
                            output_enable_strobe_b     <= cur_write;
                            read_strobe_b <= !(cur_glue && !cur_write);
                            expansion_data_lines_out   <= cur_data;
                            expansion_data_lines_oe    <= cur_write;
                        end else if (fstep == 2'h1 && !cur_write
                                     && !cur_glue) begin
                            read_strobe_b <= 1'b0;
                        end else begin
                            chip_space_select_b     <= xbfa_pkg::RST_SEL_B;
                            read_strobe_b           <= 1'b1;
                            output_enable_strobe_b  <= 1'b1;
                            write_strobe_or_wait_b  <= 1'b1;
                            expansion_data_lines_oe <= 1'b0;
                        end
                    end
                end
                default: begin
                    chip_space_select_b <= xbfa_pkg::RST_SEL_B;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Read data capture
    // ------------------------------------------------------------------
    logic f_cap;
    logic cap_d1;
    logic cap_d2;

    // Pins reach dat_s2 two cycles late, so the capture waits two cycles
    // and sees the pins as they stood at the releasing edge
    assign f_cap = state == xbfa_pkg::ST_FACC && rise_next && !cur_write
                   && (fstep == 2'h2 || (fstep == 2'h1 && cur_glue));

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rd_valid <= 1'b0;
            rd_data  <= xbfa_pkg::RST_DATA;
            busy     <= 1'b0;
            cap_d1   <= 1'b0;
            cap_d2   <= 1'b0;
        end else if (ce) begin
            rd_valid <= 1'b0;
            busy     <= state != xbfa_pkg::ST_IDLE || take;
            cap_d1   <= (a_done && !cur_write) || f_cap;
            cap_d2   <= cap_d1;
            if (cap_d2) begin
                rd_valid <= 1'b1;
                rd_data  <= dat_s2;
            end
        end
    end

endmodule : xbfa_port

// >>> dv/xbfa_asserts.sv
// Pin-level checker of the expansion bus master.
// Assumes binding onto xbfa_port; reset is asynchronous, active low.
`timescale 1ns/1ns
module xbfa_asserts (
    input wire logic        clock, rst_b, ce, rd_valid, busy, boot_valid,
    input wire logic        ctrl_oe, fifo_bus_clock,
    input wire logic        read_strobe_b, write_strobe_or_wait_b,
    input wire logic        expansion_data_lines_oe,
    input wire logic [3:0]  chip_space_select_b,
    input wire logic [31:0] boot_config, expansion_data_lines_in
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    sequence read_release; $rose(read_strobe_b); endsequence
    sequence write_low; !write_strobe_or_wait_b; endsequence
    // Outputs are unknown before the first reset edge, so look one later
    reset_float_a: assert property (disable iff (1'b0)
        !rst_b |=> !ctrl_oe && !expansion_data_lines_oe)
        else $error("bus driven");
    wake_drive_a: assert property ($rose(rst_b) |-> ##[0:4] ctrl_oe)
        else $error("bus not driven after reset");
    read_take_a: assert property (read_release |-> ##2 rd_valid)
        else $error("no read answer");
    answer_pulse_a: assert property (rd_valid |=> !rd_valid)
        else $error("answer longer than a cycle");
    strobe_sel_a: assert property ((!read_strobe_b or write_low) |->
        chip_space_select_b != 4'hF) else $error("strobe without select");
    one_space_a: assert property ($onehot0(~chip_space_select_b))
        else $error("two spaces selected");
    strobe_excl_a: assert property (
        not (write_low and !read_strobe_b)) else $error("both strobes low");
    write_drive_a: assert property (
        write_low |-> expansion_data_lines_oe && ctrl_oe)
        else $error("write without data");
    boot_take_a: assert property ($rose(boot_valid) |->
        boot_config == $past(expansion_data_lines_in))
        else $error("boot word");
    busy_read_a: assert property (!read_strobe_b |-> busy)
        else $error("idle strobe");
    clock_run_a: assert property (ce && ctrl_oe |=>
        $changed(fifo_bus_clock)) else $error("bus clock stopped");
endmodule : xbfa_asserts
bind xbfa_port xbfa_asserts xbfa_asserts_inst (.*);

// >>> dv/xbfa_partner.sv
// Model of an asynchronous peripheral or FIFO on the expansion bus pins.
// Assumes the core clock; slow holds ready low for six strobe cycles.
`timescale 1ns/1ns
module xbfa_partner #(
    parameter logic [31:0] BOOT = 32'h5A3C_96E1
) (
    input  wire logic        clock, rst_b, slow, boot_valid,
    input  wire logic        output_enable_strobe_b, write_strobe_or_wait_b,
    input  wire logic        read_strobe_b,
    input  wire logic [3:0]  byte_enable_or_low_address,
    input  wire logic [31:0] expansion_data_lines_out,
    output logic      [31:0] expansion_data_lines_in,
    output logic             peripheral_ready_input
);
    logic [31:0] mem [16];
    logic [31:0] last;
    logic [2:0]  low_cnt;
    // Released lines toggle so a stale value is never taken for data
    assign expansion_data_lines_in = !boot_valid ? BOOT :
        !output_enable_strobe_b ? mem[byte_enable_or_low_address]
        : ~last;
    always_ff @(posedge clock) begin
        last <= expansion_data_lines_in;
        if (!write_strobe_or_wait_b)
            mem[byte_enable_or_low_address] <= expansion_data_lines_out;
    end
    always_ff @(posedge clock) begin
        if (read_strobe_b && write_strobe_or_wait_b) low_cnt <= 3'h0;
        else if (low_cnt != 3'h6) low_cnt <= low_cnt + 3'h1;
    end
    // Once raised, ready stays up until the strobe ends
    assign peripheral_ready_input = !slow || low_cnt == 3'h6;
endmodule : xbfa_partner

// >>> dv/tb.sv
// Self-checking bench of the expansion bus master and its peripheral.
// Assumes 50 MHz core clock; setup 2, strobe 3, hold 1 in every space.
`timescale 1ns/1ns
module tb;
    localparam logic [31:0] STRAPS = 32'h5A3C_96E1;
    logic clock = 1'b0, rst_b = 1'b0, ce = 1'b1, slow = 1'b0, req_valid = 1'b0;
    logic [40:0] req = '0;
    logic [15:0] read_setup_count = 16'h2222, read_strobe_count = 16'h3333;
    logic [15:0] read_hold_count = 16'h1111, write_setup_count = 16'h2222;
    logic [15:0] write_strobe_count = 16'h3333, write_hold_count = 16'h1111;
    logic req_ready, rd_valid, busy, boot_valid, read_strobe_b, ctrl_oe;
    logic output_enable_strobe_b, write_strobe_or_wait_b, fifo_bus_clock;
    logic expansion_data_lines_oe, peripheral_ready_input;
    logic [31:0] rd_data, boot_config, expansion_data_lines_in;
    logic [31:0] expansion_data_lines_out;
    logic [3:0] chip_space_select_b, byte_enable_or_low_address;
    int num_errors = 0, num_checks = 0, n, w;
    // Rows: write, fifo, glueless, space, address, data or expected data
    logic [40:0] rows [7] = '{41'h101_1111_1111, 41'h132_2222_2222,
        41'h193_3333_3333, 41'h001_1111_1111, 41'h0F2_2222_2222,
        41'h0A3_3333_3333, 41'h0C1_1111_1111};
    xbfa_port xbfa_port_inst (.*, .req_write(req[40]), .req_fifo_mode(req[39]),
        .req_glueless(req[38]), .req_space(req[37:36]), .req_addr(req[35:32]),
        .req_wdata(req[31:0]));
    xbfa_partner #(.BOOT(STRAPS)) xbfa_partner_inst (.*);
    initial forever #10 clock = ~clock;
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : give_verdict
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            num_errors++;
        end
    endtask : chk
    task automatic bail(input int lim);
        if (n >= lim) begin
            num_errors++;
            give_verdict();
        end
    endtask : bail
    task automatic push(input logic [40:0] r);
        @(posedge clock);
        req <= r;
        req_valid <= 1'b1;
        n = 0;
        do begin @(negedge clock); n++; end while (!req_ready && n < 100);
        @(posedge clock);
        req_valid <= 1'b0;
        bail(100);
    endtask : push
    // Waits for the answer, counting cycles with the read strobe low
    task automatic await_read();
        w = 0;
        for (n = 0; n < 300 && rd_valid !== 1'b1; n++) begin
            @(negedge clock);
            if (read_strobe_b === 1'b0) w++;
        end
        bail(300);
    endtask : await_read
    initial begin
        repeat (4) @(posedge clock);
        chk({31'h0, ctrl_oe | expansion_data_lines_oe}, 32'h0);
        rst_b <= 1'b1;
        repeat (6) @(posedge clock);
        chk(boot_config, STRAPS);
        chk({31'h0, ctrl_oe}, 32'h1);
        $display("reset test done");
        foreach (rows[i]) begin
            push(rows[i]);
            if (!rows[i][40]) begin
                await_read();
                chk(rd_data, rows[i][31:0]);
                if (!rows[i][39]) chk(32'(w), 32'h3);
            end
        end
        $display("table test done");
        slow <= 1'b1;
        push(41'h001_1111_1111);
        await_read();
        chk(rd_data, 32'h1111_1111);
        chk({31'h0, w >= 8}, 32'h1);
        $display("ready test done");
        w = 0;
        @(posedge clock);
        req <= 41'h100_0000_00A5;
        req_valid <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(negedge clock);
            if (!req_ready) break;
            w++;
        end
        @(posedge clock);
        req_valid <= 1'b0;
        chk({31'h0, w >= 8}, 32'h1);
        for (n = 0; n < 3000 && busy !== 1'b0; n++) @(negedge clock);
        bail(3000);
        $display("queue test done");
        give_verdict();
    end
endmodule : tb
